// >>> hdl/peq_equalizer.sv
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// R1 - enabled filter corrects converter samples before downstream
// R2 - mode, sharing, merge fields pick filter mode
// R3 - dual equalization only with dual interface mode
// R4 - dual mode: nine coefficients per channel
// R5 - centre tap 18 bits, lsb 2^-16
// R6 - side taps 12 bits, lsb 2^-10..2^-16
// R7 - one weight setting for all side taps
// R8 - single equalization filters interleaved stream, single mode
// R9 - single equalization: nine programmable coefficients
// R10 - software enables time-varying only in dual-input single; code needs INTF_SINGLE_INPUT high with INTF_DUAL low
// R11 - time-varying: coefficient set alternates every sample
// R12 - each time-varying set has nine coefficients
// R13 - software loads channel A and B coefficient groups
// R14 - disabled filter passes samples unchanged, same order
module peq_equalizer
	import peq_pkg::*;
(
	input  wire logic                       CLK_SYS,
	input  wire logic                       RESET_N,
	input  wire logic [ADDR_W-1:0]          AWADDR,
	input  wire logic                       AWVALID,
	output logic                            AWREADY,
	input  wire logic [31:0]                WDATA,
	input  wire logic [3:0]                 WSTRB,
	input  wire logic                       WVALID,
	output logic                            WREADY,
	output logic [1:0]                      BRESP,
	output logic                            BVALID,
	input  wire logic                       BREADY,
	input  wire logic [ADDR_W-1:0]          ARADDR,
	input  wire logic                       ARVALID,
	output logic                            ARREADY,
	output logic [31:0]                     RDATA,
	output logic [1:0]                      RRESP,
	output logic                            RVALID,
	input  wire logic                       RREADY,
	input  wire logic                       INTF_DUAL,
	input  wire logic                       INTF_SINGLE_INPUT,
	input  wire logic signed [SAMPLE_W-1:0] SAMPLE_A,
	input  wire logic signed [SAMPLE_W-1:0] SAMPLE_B,
	input  wire logic                       SAMPLE_VALID,
	output logic signed [SAMPLE_W-1:0]      OUT_A,
	output logic signed [SAMPLE_W-1:0]      OUT_B,
	output logic                            OUT_VALID
);

	// ------------------------------------------------------------
	// decoding helpers
	// ------------------------------------------------------------
	// returns {hit, is_ctrl, is_status, is_a, is_b, index[3:0]}
	function automatic logic [8:0] decode(input logic [ADDR_W-1:0] a);
		logic [ADDR_W-1:0] rel;
		decode = '0;
		if (a == OFS_CTRL) begin
			decode = 9'h180;
		end else if (a == OFS_STATUS) begin
			decode = 9'h140;
		end else if (a >= OFS_COEF_A && a < OFS_COEF_A + ADDR_W'(4 * TAPS)
				&& a[1:0] == 2'h0) begin
			rel    = a - OFS_COEF_A;
			decode = {5'b10010, rel[5:2]};
		end else if (a >= OFS_COEF_B && a < OFS_COEF_B + ADDR_W'(4 * TAPS)
				&& a[1:0] == 2'h0) begin
			rel    = a - OFS_COEF_B;
			decode = {5'b10001, rel[5:2]};
		end
	endfunction

	// merge byte lanes of a write into the old word
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
			input logic [3:0] strb);
		for (int i = 0; i < 4; i++) begin
			merge[8*i +: 8] = strb[i] ? d[8*i +: 8] : old[8*i +: 8];
		end
	endfunction

	// register view of a coefficient: centre 18 bits, side taps 12 bits
	function automatic logic [31:0] coef_view(input logic signed [CENTRE_W-1:0] c,
			input logic [3:0] idx);
		if (idx == 4'(CENTRE)) begin
			coef_view = {14'h0000, c};
		end else begin
			coef_view = {20'h00000, c[SIDE_W-1:0]};
		end
	endfunction

	// back from the register view, side taps sign-extended from 12 bits
	function automatic logic signed [CENTRE_W-1:0] coef_store(input logic [31:0] v,
			input logic [3:0] idx);
		if (idx == 4'(CENTRE)) begin
			coef_store = v[CENTRE_W-1:0];
		end else begin
			coef_store = {{(CENTRE_W-SIDE_W){v[SIDE_W-1]}}, v[SIDE_W-1:0]};
		end
	endfunction

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	logic [31:0]                 ctrl;
	logic signed [CENTRE_W-1:0]  coef_a [TAPS];
	logic signed [CENTRE_W-1:0]  coef_b [TAPS];
	logic                        aw_full;
	logic                        w_full;
	logic [ADDR_W-1:0]           aw_addr;
	logic [31:0]                 w_data;
	logic [3:0]                  w_strb;
	logic [8:0]                  wdec;
	logic [8:0]                  rdec;
	logic                        do_write;
	peq_mode_t                   mode;
	peq_mode_t                   next_mode;
	logic signed [SAMPLE_W-1:0]  hist_a [TAPS];
	logic signed [SAMPLE_W-1:0]  hist_b [TAPS];
	logic signed [SAMPLE_W-1:0]  win_a  [TAPS];
	logic signed [SAMPLE_W-1:0]  win_b  [TAPS];
	logic signed [SAMPLE_W-1:0]  ilv_a  [TAPS];
	logic signed [SAMPLE_W-1:0]  ilv_b  [TAPS];
	logic signed [CENTRE_W-1:0]  set_b  [TAPS];
	logic signed [SAMPLE_W-1:0]  fir_a;
	logic signed [SAMPLE_W-1:0]  fir_b;
	logic                        valid_d;

	// ------------------------------------------------------------
	// axi4-lite write channel
	// ------------------------------------------------------------
	assign wdec     = decode(aw_addr);
	assign do_write = aw_full && w_full && !BVALID;

	// address and data are taken in either order, response follows both
	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			AWREADY <= 1'b1;
			WREADY  <= 1'b1;
			aw_full <= 1'b0;
			w_full  <= 1'b0;
			aw_addr <= '0;
			w_data  <= '0;
			w_strb  <= '0;
			BVALID  <= 1'b0;
			BRESP   <= RESP_OKAY;
		end else begin
			if (AWVALID && AWREADY) begin
				aw_addr <= AWADDR;
				aw_full <= 1'b1;
				AWREADY <= 1'b0;
			end
			if (WVALID && WREADY) begin
				w_data <= WDATA;
				w_strb <= WSTRB;
				w_full <= 1'b1;
				WREADY <= 1'b0;
			end
			if (do_write) begin
				BVALID <= 1'b1;
				BRESP  <= wdec[8] ? RESP_OKAY : RESP_SLVERR;
			end
			if (BVALID && BREADY) begin
				BVALID  <= 1'b0;
				aw_full <= 1'b0;
				w_full  <= 1'b0;
				AWREADY <= 1'b1;
				WREADY  <= 1'b1;
			end
		end
	end

	// control register; status is read only and ignores writes
	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			ctrl <= CTRL_RESET;
		end else if (do_write && wdec[7]) begin
			ctrl <= merge(ctrl, w_data, w_strb);  // see R2 see R7
		end
	end

	// coefficient groups for channel A and channel B
	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			for (int i = 0; i < TAPS; i++) begin
				coef_a[i] <= (i == CENTRE) ? CENTRE_RESET : SIDE_RESET;
				coef_b[i] <= (i == CENTRE) ? CENTRE_RESET : SIDE_RESET;
			end
		end else if (do_write) begin
			// nine independent words per group  see R4 see R9 see R12 see R13
			if (wdec[5]) begin
				coef_a[wdec[3:0]] <= coef_store(merge(coef_view(coef_a[wdec[3:0]],
					wdec[3:0]), w_data, w_strb), wdec[3:0]);  // see R5 see R6
			end
			if (wdec[4]) begin
				coef_b[wdec[3:0]] <= coef_store(merge(coef_view(coef_b[wdec[3:0]],
					wdec[3:0]), w_data, w_strb), wdec[3:0]);  // see R5 see R6
			end
		end
	end

	// ------------------------------------------------------------
	// axi4-lite read channel
	// ------------------------------------------------------------
	assign rdec = decode(ARADDR);

	// one read in flight; unmapped addresses answer slverr with zero data
	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			ARREADY <= 1'b1;
			RVALID  <= 1'b0;
			RDATA   <= '0;
			RRESP   <= RESP_OKAY;
		end else if (ARVALID && ARREADY) begin
			ARREADY <= 1'b0;
			RVALID  <= 1'b1;
			RRESP   <= rdec[8] ? RESP_OKAY : RESP_SLVERR;
			if (rdec[7]) begin
				RDATA <= ctrl;
			end else if (rdec[6]) begin
				RDATA <= {22'h000000, INTF_SINGLE_INPUT, INTF_DUAL, 4'h0, mode};
			end else if (rdec[5]) begin
				RDATA <= coef_view(coef_a[rdec[3:0]], rdec[3:0]);
			end else if (rdec[4]) begin
				RDATA <= coef_view(coef_b[rdec[3:0]], rdec[3:0]);
			end else begin
				RDATA <= '0;
			end
		end else if (RVALID && RREADY) begin
			RVALID  <= 1'b0;
			ARREADY <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// effective mode
	// ------------------------------------------------------------
	// illegal field combinations, or a mode that does not match the
	// interface setting, fall back to bypass rather than filter wrongly
	always_comb begin
		next_mode = PEQ_BYPASS;  // see R2
		if (ctrl[CTRL_MODE_LSB +: 2] == MODE_ON) begin
			unique case ({ctrl[CTRL_SHARE_BIT], ctrl[CTRL_MERGE_BIT]})
				2'b00: next_mode = INTF_DUAL ? PEQ_DUAL : PEQ_BYPASS;  // see R3
				2'b11: next_mode = !INTF_DUAL ? PEQ_SINGLE : PEQ_BYPASS;  // see R8
				2'b01: next_mode = (!INTF_DUAL && INTF_SINGLE_INPUT) ? PEQ_TVAR
					: PEQ_BYPASS;  // see R10
				2'b10: next_mode = PEQ_BYPASS;
			endcase
		end
	end

	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			mode <= PEQ_BYPASS;
		end else begin
			mode <= next_mode;
		end
	end

	// ------------------------------------------------------------
	// sample history
	// ------------------------------------------------------------
	// per sample pair, A is the earlier and B the later sample of the
	// interleaved stream
	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			for (int i = 0; i < TAPS; i++) begin
				hist_a[i] <= '0;
				hist_b[i] <= '0;
			end
		end else if (SAMPLE_VALID) begin
			hist_a[0] <= SAMPLE_A;
			hist_b[0] <= SAMPLE_B;
			for (int i = 1; i < TAPS; i++) begin
				hist_a[i] <= hist_a[i-1];
				hist_b[i] <= hist_b[i-1];
			end
		end
	end

	// interleaved windows: stream s[2j]=B(n-j), s[2j+1]=A(n-j)
	genvar k;
	generate
		for (k = 0; k < TAPS; k++) begin : g_win
			if (k % 2 == 0) begin : g_even
				assign ilv_a[k] = hist_a[k/2];
				assign ilv_b[k] = hist_b[k/2];
			end else begin : g_odd
				assign ilv_a[k] = hist_b[(k+1)/2];
				assign ilv_b[k] = hist_a[(k-1)/2];
			end
			// dual keeps the channels apart  see R3 see R8
			assign win_a[k] = (mode == PEQ_DUAL) ? hist_a[k] : ilv_a[k];
			assign win_b[k] = (mode == PEQ_DUAL) ? hist_b[k] : ilv_b[k];
			// single shares set A; time-varying gives B slots set B  see R11
			assign set_b[k] = (mode == PEQ_SINGLE) ? coef_a[k] : coef_b[k];
		end
	endgenerate

	// ------------------------------------------------------------
	// filters
	// ------------------------------------------------------------
	// one weight field drives both filters and every side tap  see R7
	peq_fir_mac #(
		.N      (TAPS)
	) u_fir_a (
		.win    (win_a),
		.coef   (coef_a),
		.weight (ctrl[CTRL_WEIGHT_LSB +: 3]),
		.result (fir_a)
	);

	peq_fir_mac #(
		.N      (TAPS)
	) u_fir_b (
		.win    (win_b),
		.coef   (set_b),
		.weight (ctrl[CTRL_WEIGHT_LSB +: 3]),
		.result (fir_b)
	);

	// ------------------------------------------------------------
	// output stage
	// ------------------------------------------------------------
	// bypass goes through the same two stages so the latency and order
	// do not change when the mode is switched
	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			valid_d   <= 1'b0;
			OUT_VALID <= 1'b0;
			OUT_A     <= '0;
			OUT_B     <= '0;
		end else begin
			valid_d   <= SAMPLE_VALID;
			OUT_VALID <= valid_d;
			if (valid_d) begin
				if (mode == PEQ_BYPASS) begin
					OUT_A <= hist_a[0];  // see R14
					OUT_B <= hist_b[0];  // see R14
				end else begin
					OUT_A <= fir_a;  // see R1
					OUT_B <= fir_b;  // see R1
				end
			end
		end
	end

endmodule

`default_nettype wire

// >>> hdl/peq_pkg.sv
package peq_pkg;

	// ------------------------------------------------------------
	// datapath shape
	// ------------------------------------------------------------
	localparam int SAMPLE_W  = 12;
	localparam int TAPS      = 9;
	localparam int CENTRE    = 4;
	localparam int CENTRE_W  = 18;
	localparam int SIDE_W    = 12;
	localparam int FRAC_BITS = 16;  // centre lsb weight 2^-16
	localparam int MAX_SHIFT = 6;   // side weight 2^-10 sits 6 bits above 2^-16
	localparam int ACC_W     = 36;

	// ------------------------------------------------------------
	// register map (byte addresses)
	// ------------------------------------------------------------
	localparam int          ADDR_W      = 12;
	localparam logic [11:0] OFS_CTRL    = 12'h000;
	localparam logic [11:0] OFS_STATUS  = 12'h004;
	localparam logic [11:0] OFS_COEF_A  = 12'h040;
	localparam logic [11:0] OFS_COEF_B  = 12'h080;

	// control fields
	localparam int CTRL_MODE_LSB   = 0;   // filter_mode_select, 2 bits
	localparam int CTRL_SHARE_BIT  = 4;   // coefficient_sharing
	localparam int CTRL_MERGE_BIT  = 5;   // channel_merge_select
	localparam int CTRL_WEIGHT_LSB = 8;   // side lsb weight, 3 bits
	localparam int STAT_MODE_LSB   = 0;   // effective mode, 4 bits one-hot
	localparam int STAT_DUAL_BIT   = 8;
	localparam int STAT_SINGLE_BIT = 9;

	localparam logic [1:0] MODE_OFF = 2'h0;
	localparam logic [1:0] MODE_ON  = 2'h2;

	// reset values
	localparam logic [31:0]                CTRL_RESET   = 32'h0000_0000;
	localparam logic signed [CENTRE_W-1:0] CENTRE_RESET = 18'h10000; // unity gain
	localparam logic signed [CENTRE_W-1:0] SIDE_RESET   = 18'h00000;

	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	typedef enum logic [3:0] {
		PEQ_BYPASS = 4'b0001,
		PEQ_DUAL   = 4'b0010,
		PEQ_SINGLE = 4'b0100,
		PEQ_TVAR   = 4'b1000
	} peq_mode_t;

endpackage

// >>> hdl/peq_fir_mac.sv
`timescale 1ns/100ps
`default_nettype none

module peq_fir_mac
	import peq_pkg::*;
#(
	parameter int N = TAPS
) (
	input  wire logic signed [SAMPLE_W-1:0] win    [N],
	input  wire logic signed [CENTRE_W-1:0] coef   [N],
	input  wire logic        [2:0]          weight,
	output logic signed      [SAMPLE_W-1:0] result
);

	// ------------------------------------------------------------
	// products, all aligned to the 2^-16 grid
	// ------------------------------------------------------------
	logic signed [ACC_W-1:0] prod [N];
	logic        [2:0]       shift;

	// weight codes above 2^-16 are clamped to 2^-16
	assign shift = (weight > 3'(MAX_SHIFT)) ? 3'h0 : 3'(MAX_SHIFT) - weight;  // see R6

	genvar k;
	generate
		for (k = 0; k < N; k++) begin : g_tap
			if (k == CENTRE) begin : g_centre
				assign prod[k] = ACC_W'(win[k] * coef[k]);
			end else begin : g_side
				logic signed [SIDE_W-1:0] c;
				assign c       = coef[k][SIDE_W-1:0];
				assign prod[k] = ACC_W'(win[k] * c) <<< shift;
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// sum, then a single convergent rounding and saturation
	// ------------------------------------------------------------
	// no rounding inside the sum, so the only error is at the output
	always_comb begin
		logic signed [ACC_W-1:0]           acc;
		logic signed [ACC_W-FRAC_BITS:0]   whole;
		logic        [FRAC_BITS-1:0]       frac;
		acc   = '0;
		whole = '0;
		frac  = '0;
		for (int i = 0; i < N; i++) begin
			acc = acc + prod[i];
		end
		frac  = acc[FRAC_BITS-1:0];
		// arithmetic shift keeps the sign; a bare part-select would zero-extend
		whole = (ACC_W-FRAC_BITS+1)'(acc >>> FRAC_BITS);
		if (frac > 16'h8000 || (frac == 16'h8000 && whole[0])) begin
			whole = whole + (ACC_W-FRAC_BITS+1)'(1);
		end
		if (whole > (ACC_W-FRAC_BITS+1)'(2**(SAMPLE_W-1) - 1)) begin
			result = {1'b0, {(SAMPLE_W-1){1'b1}}};
		end else if (whole < -(ACC_W-FRAC_BITS+1)'(2**(SAMPLE_W-1))) begin
			result = {1'b1, {(SAMPLE_W-1){1'b0}}};
		end else begin
			result = whole[SAMPLE_W-1:0];
		end
	end

endmodule

`default_nettype wire

// >>> tb/peq_adc_src.sv
`timescale 1ns/100ps
`default_nettype none

// ----
// converter-core sample source
// ----
module peq_adc_src
	import peq_pkg::*;
(
	input  wire logic                clk,
	input  wire logic                rst_n,
	input  wire logic                en,
	input  wire logic                slow,
	output logic signed [SAMPLE_W-1:0] a,
	output logic signed [SAMPLE_W-1:0] b,
	output logic                     v
);
	// one pair per cycle, or gapped; idle data toggles so stale values never match
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			v <= 1'b0;
			a <= 12'h000;
			b <= 12'h000;
		end else if (en && (!slow || $urandom_range(1) == 1)) begin
			v <= 1'b1;
			a <= 12'($urandom);
			b <= 12'($urandom);
		end else begin
			v <= 1'b0;
			a <= ~a;
			b <= ~b;
		end
	end
endmodule
`default_nettype wire

// >>> tb/peq_equalizer_chk.sv
`timescale 1ns/100ps
`default_nettype none

// ----
// port checks of the equalizer
// ----
module peq_equalizer_chk
	import peq_pkg::*;
(
	input wire logic                      CLK_SYS,
	input wire logic                      RESET_N,
	input wire logic                      AWVALID,
	input wire logic                      AWREADY,
	input wire logic                      WVALID,
	input wire logic                      WREADY,
	input wire logic [1:0]                BRESP,
	input wire logic                      BVALID,
	input wire logic                      BREADY,
	input wire logic                      ARVALID,
	input wire logic                      ARREADY,
	input wire logic [31:0]               RDATA,
	input wire logic [1:0]                RRESP,
	input wire logic                      RVALID,
	input wire logic                      RREADY,
	input wire logic                      SAMPLE_VALID,
	input wire logic signed [SAMPLE_W-1:0] OUT_A,
	input wire logic signed [SAMPLE_W-1:0] OUT_B,
	input wire logic                      OUT_VALID
);
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!RESET_N);

	// both halves of a write taken at one edge
	sequence wr_taken_s;
		AWVALID && AWREADY && WVALID && WREADY;
	endsequence
	sequence rd_taken_s;
		ARVALID && ARREADY;
	endsequence
	// both halves refused, then the response two edges after the write is taken
	sequence wr_answer_s;
		!AWREADY && !WREADY ##1 BVALID;
	endsequence

	// bus answers and refusals
	wr_answer_a: assert property (wr_taken_s |=> wr_answer_s)
		else $error("write answer late");
	rd_answer_a: assert property (rd_taken_s |=> RVALID && !ARREADY)
		else $error("read answer late");
	bresp_hold_a: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
		else $error("write response dropped");
	rdata_hold_a: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
		else $error("read data dropped");
	b_close_a: assert property (BVALID && BREADY |=> !BVALID && AWREADY && WREADY)
		else $error("write not closed");
	r_close_a: assert property (RVALID && RREADY |=> !RVALID && ARREADY)
		else $error("read not closed");
	err_data_a: assert property (RVALID && RRESP == RESP_SLVERR |-> RDATA == 32'h0)
		else $error("error read carries data");

	// sample path: fixed two-cycle latency, outputs hold between pairs
	out_lat_a: assert property (SAMPLE_VALID |-> ##2 OUT_VALID)
		else $error("output pair missing");
	out_gap_a: assert property (!SAMPLE_VALID |-> ##2 !OUT_VALID)
		else $error("spurious output pair");
	out_hold_a: assert property (!OUT_VALID |-> $stable(OUT_A) && $stable(OUT_B))
		else $error("output moved without valid");
endmodule

bind peq_equalizer peq_equalizer_chk i_chk (.CLK_SYS, .RESET_N, .AWVALID, .AWREADY, .WVALID,
	.WREADY, .BRESP, .BVALID, .BREADY, .ARVALID, .ARREADY, .RDATA, .RRESP, .RVALID, .RREADY,
	.SAMPLE_VALID, .OUT_A, .OUT_B, .OUT_VALID);
`default_nettype wire

// >>> tb/programmable_equalization_fir_test.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, exp, got) begin total_checks++; if ((got) !== (exp)) begin failures++; \
	$display("FAIL %s expected %h seen %h", nm, exp, got); end end

module programmable_equalization_fir_test
	import peq_pkg::*;
();
	logic CLK_SYS = 0, RESET_N = 0, AWVALID = 0, WVALID = 0, BREADY = 0, ARVALID = 0, RREADY = 0;
	logic INTF_DUAL = 0, INTF_SINGLE_INPUT = 0, run = 0, slow = 0;
	logic [ADDR_W-1:0] AWADDR = 12'h000, ARADDR = 12'h000;
	logic [31:0] WDATA = 32'h0, RDATA;
	logic [3:0] WSTRB = 4'hF;
	logic AWREADY, WREADY, BVALID, ARREADY, RVALID, SAMPLE_VALID, OUT_VALID;
	logic [1:0] BRESP, RRESP;
	logic signed [SAMPLE_W-1:0] SAMPLE_A, SAMPLE_B, OUT_A, OUT_B;
	int failures = 0, total_checks = 0, cyc = 0, npairs = 0, emode = 0, ws = 0;
	int coef [2][TAPS];
	int ha[$] = '{0, 0, 0, 0, 0, 0, 0, 0, 0}, hb[$] = '{0, 0, 0, 0, 0, 0, 0, 0, 0};
	int hs[$] = '{0, 0, 0, 0, 0, 0, 0, 0, 0};
	logic [24:0] eq[$];

	peq_equalizer i_dut (.CLK_SYS, .RESET_N, .AWADDR, .AWVALID, .AWREADY, .WDATA, .WSTRB,
		.WVALID, .WREADY, .BRESP, .BVALID, .BREADY, .ARADDR, .ARVALID, .ARREADY, .RDATA,
		.RRESP, .RVALID, .RREADY, .INTF_DUAL, .INTF_SINGLE_INPUT, .SAMPLE_A, .SAMPLE_B,
		.SAMPLE_VALID, .OUT_A, .OUT_B, .OUT_VALID);
	peq_adc_src i_src (.clk(CLK_SYS), .rst_n(RESET_N), .en(run), .slow(slow), .a(SAMPLE_A),
		.b(SAMPLE_B), .v(SAMPLE_VALID));

	// ----
	// reference arithmetic
	// ----
	// exact sum at 2^-16, round half to even, clip to 12 bits
	function automatic int fir(int h[$], bit sb);
		longint acc;
		longint q;
		acc = 0;
		for (int k = 0; k < TAPS; k++)
			acc += longint'(coef[sb][k]) * h[k] * ((k == CENTRE) ? 1 : (1 << (MAX_SHIFT - ws)));
		q = acc >>> FRAC_BITS;
		if (acc[15:0] > 16'h8000 || (acc[15:0] == 16'h8000 && q[0]))
			q++;
		return (q > 2047) ? 2047 : (q < -2048) ? -2048 : int'(q);
	endfunction

	// cfg = {mode[1:0], share, merge, dual, single_input, weight[2:0]}
	function automatic int eff(logic [8:0] c);
		if (c[8:7] != MODE_ON)
			return 0;
		if (!c[6] && !c[5])
			return c[4] ? 1 : 0;
		if (c[6] && c[5])
			return c[4] ? 0 : 2;
		if (!c[6] && c[5])
			return (!c[4] && c[3]) ? 3 : 0;
		return 0;
	endfunction

	// ----
	// bus tasks
	// ----
	task automatic axw(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge CLK_SYS);
		AWADDR <= a;
		WDATA <= d;
		AWVALID <= 1'b1;
		WVALID <= 1'b1;
		BREADY <= 1'b1;
		forever begin
			@(posedge CLK_SYS);
			if (AWREADY)
				AWVALID <= 1'b0;
			if (WREADY)
				WVALID <= 1'b0;
			if (BVALID) begin
				r = BRESP;
				BREADY <= 1'b0;
				break;
			end
		end
	endtask

	task automatic axr(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge CLK_SYS);
		ARADDR <= a;
		ARVALID <= 1'b1;
		RREADY <= 1'b1;
		forever begin
			@(posedge CLK_SYS);
			if (ARREADY)
				ARVALID <= 1'b0;
			if (RVALID) begin
				d = RDATA;
				r = RRESP;
				RREADY <= 1'b0;
				break;
			end
		end
	endtask

	task automatic final_report();
		if (failures == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	always #25 CLK_SYS = ~CLK_SYS;

	// hang guard, well above the expected run of about 1800 cycles
	always @(posedge CLK_SYS) begin
		cyc++;
		if (cyc == 20000) begin
			failures++;
			final_report();
		end
	end

	// expected pairs queued at the taking edge, matched at output; first pairs only fill history
	always @(posedge CLK_SYS) begin
		logic [11:0] ea;
		logic [11:0] eb;
		logic [24:0] e;
		if (RESET_N && SAMPLE_VALID) begin
			ha.push_front(SAMPLE_A);
			hb.push_front(SAMPLE_B);
			hs.push_front(SAMPLE_A);
			ea = 12'(emode == 1 ? fir(ha, 0) : emode >= 2 ? fir(hs, 0) : int'(SAMPLE_A));
			hs.push_front(SAMPLE_B);
			eb = 12'(emode == 1 ? fir(hb, 1) : emode >= 2 ? fir(hs, emode == 3) : int'(SAMPLE_B));
			npairs++;
			eq.push_back({npairs > 9, ea, eb});
		end
		if (RESET_N && OUT_VALID) begin
			if (eq.size() == 0)
				`CHK("out_valid", 1'b0, OUT_VALID)
			else begin
				e = eq.pop_front();
				if (e[24]) begin
					`CHK("out_a", e[23:12], OUT_A)
					`CHK("out_b", e[11:0], OUT_B)
				end
			end
		end
	end

	// ----
	// main sequence
	// ----
	initial begin
		logic [1:0] r;
		logic [31:0] d;
		logic [31:0] m;
		static logic [8:0] cfg [9] = '{9'h070, 9'h110, 9'h105, 9'h166, 9'h12B, 9'h152, 9'h091,
			9'h117, 9'h174};
		void'($urandom(32'h42A4));
		repeat (8) @(posedge CLK_SYS);
		RESET_N <= 1'b1;
		axr(OFS_CTRL, d, r);
		`CHK("ctrl_reset", CTRL_RESET, d)
		axr(12'(OFS_COEF_A + 16), d, r);
		`CHK("centre_reset", 32'h00010000, d)
		axr(12'hFFC, d, r);
		`CHK("unmapped_rresp", RESP_SLVERR, r)
		axw(12'hFFC, 32'h5A5A5A5A, r);
		`CHK("unmapped_bresp", RESP_SLVERR, r)
		// each mode entry, with interface settings matching and not (time-varying with matching settings only)
		foreach (cfg[i]) begin
			INTF_DUAL <= cfg[i][4];
			INTF_SINGLE_INPUT <= cfg[i][3];
			axw(OFS_CTRL, {21'h0, cfg[i][2:0], 2'h0, cfg[i][5], cfg[i][6], 2'h0, cfg[i][8:7]}, r);
			for (int s = 0; s < 2; s++) begin
				for (int k = 0; k < TAPS; k++) begin
					m = (k == CENTRE) ? 32'h0003FFFF : 32'h00000FFF;
					coef[s][k] = (k == CENTRE) ? 57344 + int'($urandom_range(16383))
						: int'($urandom_range(1023)) - 512;
					axw(12'((s ? OFS_COEF_B : OFS_COEF_A) + 4 * k), (coef[s][k] & m) | ($urandom & ~m), r);
					axr(12'((s ? OFS_COEF_B : OFS_COEF_A) + 4 * k), d, r);
					`CHK("coef_readback", m & coef[s][k], d)
				end
			end
			emode = eff(cfg[i]);
			ws = (cfg[i][2:0] > 6) ? 6 : int'(cfg[i][2:0]);
			axr(OFS_STATUS, d, r);
			`CHK("status", 32'(1 << emode) | {22'h0, cfg[i][3], cfg[i][4], 8'h00}, d)
			slow <= i[0];
			run <= 1'b1;
			repeat (60) @(posedge CLK_SYS);
			run <= 1'b0;
			repeat (4) @(posedge CLK_SYS);
		end
		`CHK("drained", 0, eq.size())
		final_report();
	end
endmodule
`default_nettype wire
